// >>> rtl/nths_pkg.sv
// Contract
// - selected file register holds the file identifier of the latest Select, host readable and writable.
// - file identifier bits 15-8 hold the second ID byte, 03h for capability container.
// - file identifier bits 7-0 hold the first ID byte, E1h for capability container.
// - extra-data bit 1 means extra buffer data and size update, 0 means none.
// - prefetch on read is honoured only while the extra-data interrupt enable is set.
// - reply bit 2 selects custom status word, otherwise default status word.
// - host writes bit 1 as file exists answer; device answers Select with it.
// - serviced bit set to 1 completes service and starts processing the pending reply.
// - block length of Read or Update Binary reported in 16-bit register, high byte odd.
// - file offset of Read or Update Binary reported in 16-bit register, high byte odd.
// - general request interrupt raised for every Select, Read or Update Binary needing service.
// - read prefetch interrupt raised once Read Binary is serviced and transmission starts.
package nths_pkg;

    localparam logic [15:0] NTHS_ADDR_OFFSET = 16'hFFE6;
    localparam logic [15:0] NTHS_ADDR_LENGTH = 16'hFFE8;
    localparam logic [15:0] NTHS_ADDR_REPLY  = 16'hFFEA;
    localparam logic [15:0] NTHS_ADDR_FILEID = 16'hFFEC;

    localparam int NTHS_BIT_SERVICED  = 0;
    localparam int NTHS_BIT_EXISTS    = 1;
    localparam int NTHS_BIT_CUSTOM_SW = 2;
    localparam int NTHS_BIT_EXTRA     = 3;

    localparam logic [15:0] NTHS_REPLY_MASK  = 16'h000F;
    localparam logic [15:0] NTHS_RESET_VALUE = 16'h0000;
    localparam logic [7:0]  NTHS_BYTE_ZERO   = 8'h00;

    typedef enum logic [1:0] {
        NTHS_CMD_SELECT = 2'h0,
        NTHS_CMD_READ   = 2'h1,
        NTHS_CMD_UPDATE = 2'h2
    } nths_cmd_t;

    typedef enum logic [3:0] {
        NTHS_ST_IDLE     = 4'h1,
        NTHS_ST_WAIT     = 4'h2,
        NTHS_ST_RESPOND  = 4'h4,
        NTHS_ST_PREFETCH = 4'h8
    } nths_state_t;

    typedef struct packed {
        nths_cmd_t   kind;
        logic [15:0] file_id;
        logic [15:0] offset;
        logic [15:0] length;
    } nths_cmd_req_t;

    typedef struct packed {
        nths_cmd_t kind;
        logic      file_exists;
        logic      use_custom_sw;
        logic      extra_data;
    } nths_reply_t;

endpackage

// >>> rtl/nths_reg16.sv
`timescale 1ns/1ps
`default_nettype none
module nths_reg16
    import nths_pkg::*;
#(
    parameter logic [15:0] ADDR  = 16'h0000,
    parameter logic [15:0] WMASK = 16'hFFFF
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [15:0] addr,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_data,
    input  wire logic        load,
    input  wire logic [15:0] load_data,
    output logic             hit,
    output logic [7:0]       rd_byte,
    output logic [15:0]      value
);
    wire logic hit_lo = (addr == ADDR);
    wire logic hit_hi = (addr == (ADDR | 16'h0001));

    // ****************************************
    // byte lanes
    // ****************************************
    assign hit     = hit_lo | hit_hi;
    assign rd_byte = hit_hi ? value[15:8] : value[7:0];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            value <= NTHS_RESET_VALUE;
        end else if (load) begin
            value <= load_data;
        end else if (wr_en && hit_lo) begin
            value[7:0] <= wr_data & WMASK[7:0];
        end else if (wr_en && hit_hi) begin
            value[15:8] <= wr_data & WMASK[15:8];
        end
    end
endmodule
`default_nettype wire

// >>> rtl/nths_host_regs.sv
`timescale 1ns/1ps
`default_nettype none
module nths_host_regs (
    input  wire logic                    clk_sys,
    input  wire logic                    nrst,
    input  wire logic [15:0]             reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic [7:0]              reg_wdata,
    output logic [7:0]                   reg_rdata,
    output logic                         reg_hit,
    input  wire logic                    cmd_valid,
    output logic                         cmd_ready,
    input  wire nths_pkg::nths_cmd_req_t cmd_req,
    input  wire logic                    tx_started,
    input  wire logic                    extra_irq_en,
    output logic                         irq_general,
    output logic                         irq_prefetch,
    output logic                         reply_valid,
    output nths_pkg::nths_reply_t        reply
);
    import nths_pkg::*;

    nths_state_t   state;
    nths_state_t   next_state;
    nths_cmd_t     kind;
    logic [15:0]   off_q;
    logic [15:0]   len_q;
    logic [15:0]   fid_q;
    logic [15:0]   rep_q;
    logic [7:0]    rd_off;
    logic [7:0]    rd_len;
    logic [7:0]    rd_rep;
    logic [7:0]    rd_fid;
    logic          hit_off;
    logic          hit_len;
    logic          hit_rep;
    logic          hit_fid;

    // ****************************************
    // command capture and decode
    // ****************************************
    wire logic take_cmd   = cmd_valid & cmd_ready;
    wire logic serviced   = rep_q[NTHS_BIT_SERVICED];
    wire logic done_wait  = (state == NTHS_ST_WAIT) & serviced;
    wire logic clr_serv   = done_wait | ((state == NTHS_ST_PREFETCH) & tx_started);
    wire logic [15:0] rep_load = {rep_q[15:1], 1'b0};

    assign cmd_ready = (state == NTHS_ST_IDLE);

    nths_reg16 #(.ADDR(NTHS_ADDR_OFFSET), .WMASK(16'hFFFF)) u_off (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .addr      (reg_addr),
        .wr_en     (reg_wr),
        .wr_data   (reg_wdata),
        .load      (take_cmd),
        .load_data (cmd_req.offset),
        .hit       (hit_off),
        .rd_byte   (rd_off),
        .value     (off_q)
    );

    nths_reg16 #(.ADDR(NTHS_ADDR_LENGTH), .WMASK(16'hFFFF)) u_len (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .addr      (reg_addr),
        .wr_en     (reg_wr),
        .wr_data   (reg_wdata),
        .load      (take_cmd),
        .load_data (cmd_req.length),
        .hit       (hit_len),
        .rd_byte   (rd_len),
        .value     (len_q)
    );

    nths_reg16 #(.ADDR(NTHS_ADDR_REPLY), .WMASK(NTHS_REPLY_MASK)) u_rep (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .addr      (reg_addr),
        .wr_en     (reg_wr),
        .wr_data   (reg_wdata),
        .load      (clr_serv),
        .load_data (rep_load),
        .hit       (hit_rep),
        .rd_byte   (rd_rep),
        .value     (rep_q)
    );

    wire logic load_fid = take_cmd & (cmd_req.kind == NTHS_CMD_SELECT);

    nths_reg16 #(.ADDR(NTHS_ADDR_FILEID), .WMASK(16'hFFFF)) u_fid (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .addr      (reg_addr),
        .wr_en     (reg_wr),
        .wr_data   (reg_wdata),
        .load      (load_fid),
        .load_data (cmd_req.file_id),
        .hit       (hit_fid),
        .rd_byte   (rd_fid),
        .value     (fid_q)
    );

    assign reg_hit   = hit_off | hit_len | hit_rep | hit_fid;
    assign reg_rdata = hit_off ? rd_off :
                       hit_len ? rd_len :
                       hit_rep ? rd_rep :
                       hit_fid ? rd_fid : NTHS_BYTE_ZERO;

    // ****************************************
    // service sequence
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            NTHS_ST_IDLE: begin
                if (cmd_valid) begin
                    next_state = NTHS_ST_WAIT;
                end
            end
            NTHS_ST_WAIT: begin
                if (serviced) begin
                    next_state = NTHS_ST_RESPOND;
                end
            end
            NTHS_ST_RESPOND: begin
                if (kind == NTHS_CMD_READ && extra_irq_en) begin
                    next_state = NTHS_ST_PREFETCH;
                end else begin
                    next_state = NTHS_ST_IDLE;
                end
            end
            NTHS_ST_PREFETCH: begin
                if (tx_started) begin
                    next_state = NTHS_ST_IDLE;
                end
            end
            default: begin
                next_state = NTHS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= NTHS_ST_IDLE;
            kind  <= NTHS_CMD_SELECT;
        end else begin
            state <= next_state;
            if (take_cmd) begin
                kind <= cmd_req.kind;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_general  <= 1'b0;
            irq_prefetch <= 1'b0;
            reply_valid  <= 1'b0;
            reply        <= '0;
        end else begin
            irq_general  <= take_cmd;
            irq_prefetch <= (state == NTHS_ST_PREFETCH) & tx_started;
            reply_valid  <= done_wait;
            if (done_wait) begin
                reply.kind          <= kind;
                reply.file_exists   <= rep_q[NTHS_BIT_EXISTS];
                reply.use_custom_sw <= rep_q[NTHS_BIT_CUSTOM_SW];
                reply.extra_data    <= rep_q[NTHS_BIT_EXTRA] & extra_irq_en;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    general_irq_a: assert property (take_cmd |=> irq_general)
        else $error("general irq missing");
    fid_capture_a: assert property (load_fid |=> fid_q == $past(cmd_req.file_id))
        else $error("file id not captured");
    len_capture_a: assert property (take_cmd |=> len_q == $past(cmd_req.length))
        else $error("length not captured");
    off_capture_a: assert property (take_cmd |=> off_q == $past(cmd_req.offset))
        else $error("offset not captured");
    serviced_reply_a: assert property (done_wait |=> reply_valid && state == NTHS_ST_RESPOND)
        else $error("serviced not honoured");
    custom_sw_a: assert property (done_wait |=> reply.use_custom_sw == $past(rep_q[NTHS_BIT_CUSTOM_SW]))
        else $error("custom sw mismatch");
    exists_a: assert property (done_wait |=> reply.file_exists == $past(rep_q[NTHS_BIT_EXISTS]))
        else $error("file exists mismatch");
    extra_gate_a: assert property (reply_valid && !$past(extra_irq_en) |-> !reply.extra_data)
        else $error("extra data not gated");
    reserved_zero_a: assert property (rep_q[15:4] == 12'h000)
        else $error("reserved reply bits set");
    prefetch_irq_a: assert property (irq_prefetch |-> $past(state) == NTHS_ST_PREFETCH)
        else $error("prefetch irq outside read");

    // ****************************************
    // interrupt and sequence checks
    // ****************************************
    general_pulse_a: assert property (irq_general |=> !irq_general)
        else $error("general irq longer than one cycle");
    general_cause_a: assert property (irq_general |-> $past(take_cmd))
        else $error("general irq without command");
    general_wait_a: assert property (irq_general |-> state == NTHS_ST_WAIT)
        else $error("general irq outside service wait");
    state_onehot_a: assert property ($onehot(state))
        else $error("service state not one-hot");
    kind_capture_a: assert property (take_cmd |=> kind == $past(cmd_req.kind))
        else $error("command kind not captured");
    take_wait_a: assert property (take_cmd |=> state == NTHS_ST_WAIT && !cmd_ready)
        else $error("command not held for service");
    wait_hold_a: assert property (state == NTHS_ST_WAIT && !serviced |=>
        state == NTHS_ST_WAIT && !reply_valid)
        else $error("reply before serviced bit");
    reply_cause_a: assert property (reply_valid |-> $past(done_wait))
        else $error("reply without service");
    reply_pulse_a: assert property (reply_valid |=> !reply_valid)
        else $error("reply longer than one cycle");
    reply_state_a: assert property (reply_valid |-> state == NTHS_ST_RESPOND)
        else $error("reply outside respond state");
    reply_kind_a: assert property (done_wait |=> reply.kind == $past(kind))
        else $error("reply kind mismatch");
    reply_hold_a: assert property (!done_wait |=> $stable(reply))
        else $error("reply changed without service");
    respond_leave_a: assert property (state == NTHS_ST_RESPOND |=>
        state == NTHS_ST_IDLE || state == NTHS_ST_PREFETCH)
        else $error("respond state not left");
    serviced_clear_a: assert property (done_wait |=> !rep_q[NTHS_BIT_SERVICED])
        else $error("serviced bit not cleared");
    reply_keep_a: assert property (done_wait |=> rep_q[NTHS_BIT_EXTRA:NTHS_BIT_EXISTS] ==
        $past(rep_q[NTHS_BIT_EXTRA:NTHS_BIT_EXISTS]))
        else $error("reply flags lost on service");
    extra_pass_a: assert property (done_wait && extra_irq_en |=>
        reply.extra_data == $past(rep_q[NTHS_BIT_EXTRA]))
        else $error("extra data not passed");
    prefetch_enter_a: assert property (state == NTHS_ST_RESPOND && extra_irq_en &&
        kind == NTHS_CMD_READ |=> state == NTHS_ST_PREFETCH)
        else $error("prefetch wait skipped");
    prefetch_skip_a: assert property (state == NTHS_ST_RESPOND && !extra_irq_en |=>
        state == NTHS_ST_IDLE && !irq_prefetch)
        else $error("prefetch without enable");
    prefetch_hold_a: assert property (state == NTHS_ST_PREFETCH && !tx_started |=>
        state == NTHS_ST_PREFETCH && !irq_prefetch)
        else $error("prefetch wait left early");
    prefetch_leave_a: assert property (state == NTHS_ST_PREFETCH && tx_started |=>
        irq_prefetch && state == NTHS_ST_IDLE && !rep_q[NTHS_BIT_SERVICED])
        else $error("prefetch irq missing");
    prefetch_pulse_a: assert property (irq_prefetch |=> !irq_prefetch)
        else $error("prefetch irq longer than one cycle");
    prefetch_kind_a: assert property (irq_prefetch |-> $past(kind) == NTHS_CMD_READ)
        else $error("prefetch irq after non-read");

    // ****************************************
    // register map checks
    // ****************************************
    hit_map_a: assert property (reg_hit == (reg_addr >= NTHS_ADDR_OFFSET &&
        reg_addr <= (NTHS_ADDR_FILEID | 16'h0001)))
        else $error("register hit outside map");
    unmapped_a: assert property (!reg_hit |-> reg_rdata == NTHS_BYTE_ZERO)
        else $error("unmapped read not zero");
    rd_off_lo_a: assert property (reg_addr == NTHS_ADDR_OFFSET |->
        reg_rdata == off_q[7:0])
        else $error("offset low byte read");
    rd_off_hi_a: assert property (reg_addr == (NTHS_ADDR_OFFSET | 16'h0001) |->
        reg_rdata == off_q[15:8])
        else $error("offset high byte read");
    rd_len_lo_a: assert property (reg_addr == NTHS_ADDR_LENGTH |->
        reg_rdata == len_q[7:0])
        else $error("length low byte read");
    rd_len_hi_a: assert property (reg_addr == (NTHS_ADDR_LENGTH | 16'h0001) |->
        reg_rdata == len_q[15:8])
        else $error("length high byte read");
    rd_fid_lo_a: assert property (reg_addr == NTHS_ADDR_FILEID |->
        reg_rdata == fid_q[7:0])
        else $error("file id low byte read");
    rd_fid_hi_a: assert property (reg_addr == (NTHS_ADDR_FILEID | 16'h0001) |->
        reg_rdata == fid_q[15:8])
        else $error("file id high byte read");
    rd_rep_lo_a: assert property (reg_addr == NTHS_ADDR_REPLY |->
        reg_rdata == rep_q[7:0])
        else $error("reply low byte read");
    rd_rep_hi_a: assert property (reg_addr == (NTHS_ADDR_REPLY | 16'h0001) |->
        reg_rdata == NTHS_BYTE_ZERO)
        else $error("reply high byte not zero");
    wr_len_lo_a: assert property (reg_wr && reg_addr == NTHS_ADDR_LENGTH && !take_cmd |=>
        len_q[7:0] == $past(reg_wdata))
        else $error("length low byte write");
    wr_off_hi_a: assert property (reg_wr && reg_addr == (NTHS_ADDR_OFFSET | 16'h0001) && !take_cmd |=>
        off_q[15:8] == $past(reg_wdata))
        else $error("offset high byte write");
    wr_fid_lo_a: assert property (reg_wr && reg_addr == NTHS_ADDR_FILEID && !load_fid |=>
        fid_q[7:0] == $past(reg_wdata))
        else $error("file id low byte write");
    wr_fid_hi_a: assert property (reg_wr && reg_addr == (NTHS_ADDR_FILEID | 16'h0001) && !load_fid |=>
        fid_q[15:8] == $past(reg_wdata))
        else $error("file id high byte write");
    wr_rep_a: assert property (reg_wr && reg_addr == NTHS_ADDR_REPLY && !clr_serv |=>
        rep_q[NTHS_BIT_EXTRA:NTHS_BIT_SERVICED] == $past(reg_wdata[NTHS_BIT_EXTRA:NTHS_BIT_SERVICED]))
        else $error("reply byte write");
    fid_keep_a: assert property (take_cmd && cmd_req.kind != NTHS_CMD_SELECT && !reg_wr |=>
        $stable(fid_q))
        else $error("file id changed by non-select");

    select_cov: cover property (load_fid ##[1:20] reply_valid);
    read_pf_cov: cover property (state == NTHS_ST_PREFETCH ##[1:20] irq_prefetch);
    custom_cov: cover property (reply_valid && reply.use_custom_sw);
    update_cov: cover property ((take_cmd && cmd_req.kind == NTHS_CMD_UPDATE) ##[1:20] reply_valid);
endmodule
`default_nettype wire

// >>> verif/nths_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module nths_host_model (
    input  wire logic        clk_sys,
    input  wire logic        irq_general,
    input  wire logic [7:0]  reply_byte,
    input  wire logic [7:0]  reg_rdata,
    output logic [15:0]      reg_addr,
    output logic             reg_wr,
    output logic [7:0]       reg_wdata
);
    import nths_pkg::*;
    // ****************
    // host byte access
    // ****************
    initial begin
        reg_addr  = 16'h0000;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
    // slow service of each general request, reply written after the interrupt
    initial forever begin
        @(posedge clk_sys);
        if (irq_general === 1'b1) begin
            repeat (3) @(posedge clk_sys);
            wr(NTHS_ADDR_REPLY, reply_byte);
        end
    end
endmodule
`default_nettype wire

// >>> verif/nfc_type4_host_service_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module nfc_type4_host_service_regs_bench;
    import nths_pkg::*;
    logic          clk_sys, nrst, reg_wr, reg_hit, cmd_valid, cmd_ready;
    logic          tx_started, extra_irq_en, irq_general, irq_prefetch, reply_valid;
    logic [15:0]   reg_addr;
    logic [7:0]    reg_wdata, reg_rdata, rep_b, d, v;
    nths_cmd_req_t cmd_req;
    nths_reply_t   reply;
    int            bad_count, num_checks, i;
    nths_host_regs DUT (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_req(cmd_req), .tx_started(tx_started), .extra_irq_en(extra_irq_en),
        .irq_general(irq_general), .irq_prefetch(irq_prefetch), .reply_valid(reply_valid), .reply(reply));
    nths_host_model HOST (.clk_sys(clk_sys), .irq_general(irq_general), .reply_byte(rep_b),
        .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ***********
    // check tasks
    // ***********
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        HOST.rd(a, d);
        chk({8'h00, d}, {8'h00, e});
    endtask
    task automatic cmd(input nths_cmd_t k, input logic [15:0] f, o, l, input logic [7:0] r, input logic pf);
        @(posedge clk_sys);
        rep_b     <= r;
        cmd_valid <= 1'b1;
        cmd_req   <= '{k, f, o, l};
        @(posedge clk_sys);
        while (cmd_ready !== 1'b1) @(posedge clk_sys);
        cmd_valid <= 1'b0;
        for (i = 0; i < 50 && reply_valid !== 1'b1; i++) @(posedge clk_sys);
        chk(i < 50, 1'b1);
        chk(reply.kind, k);
        chk(reply.file_exists, r[1]);
        chk(reply.use_custom_sw, r[2]);
        chk(reply.extra_data, r[3] & extra_irq_en);
        if (pf) begin
            @(posedge clk_sys);
            tx_started <= 1'b1;
            @(posedge clk_sys);
            tx_started <= 1'b0;
            for (i = 0; i < 20 && irq_prefetch !== 1'b1; i++) @(posedge clk_sys);
            chk(i < 20, 1'b1);
        end
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // *********
    // sequences
    // *********
    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        end_of_test();
    end
    initial begin
        nrst         = 1'b0;
        cmd_valid    = 1'b0;
        tx_started   = 1'b0;
        extra_irq_en = 1'b0;
        cmd_req      = '0;
        rep_b        = 8'h00;
        bad_count    = 0;
        num_checks   = 0;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int a = 16'hFFE6; a <= 16'hFFEE; a++) rdchk(a[15:0], 8'h00);
        chk(reg_hit, 1'b0);
        $display("test reset done");
        for (int a = 16'hFFE6; a <= 16'hFFEE; a++) HOST.wr(a[15:0], a[7:0] ^ 8'h5A);
        for (int a = 16'hFFE6; a <= 16'hFFEE; a++) begin
            v = (a == 16'hFFEA) ? 8'h00 : (a == 16'hFFEB || a == 16'hFFEE) ? 8'h00 : a[7:0] ^ 8'h5A;
            rdchk(a[15:0], v);
        end
        $display("test registers done");
        cmd(NTHS_CMD_SELECT, 16'h03E1, 16'h0102, 16'h0304, 8'h07, 1'b0);
        rdchk(16'hFFEC, 8'hE1);
        rdchk(16'hFFED, 8'h03);
        rdchk(16'hFFEA, 8'h06);
        $display("test select done");
        extra_irq_en <= 1'b1;
        cmd(NTHS_CMD_READ, 16'hBEEF, 16'h1234, 16'h00FF, 8'h01, 1'b1);
        rdchk(16'hFFE6, 8'h34);
        rdchk(16'hFFE7, 8'h12);
        rdchk(16'hFFE8, 8'hFF);
        rdchk(16'hFFE9, 8'h00);
        rdchk(16'hFFEC, 8'hE1);
        HOST.wr(NTHS_ADDR_REPLY, 8'h08);
        cmd(NTHS_CMD_READ, 16'h0000, 16'h0040, 16'h0020, 8'h09, 1'b1);
        extra_irq_en <= 1'b0;
        cmd(NTHS_CMD_READ, 16'h0000, 16'h0060, 16'h0020, 8'h09, 1'b0);
        $display("test read done");
        cmd(NTHS_CMD_UPDATE, 16'h0000, 16'hABCD, 16'h0110, 8'h01, 1'b0);
        rdchk(16'hFFE7, 8'hAB);
        rdchk(16'hFFE9, 8'h01);
        $display("test update done");
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        rdchk(16'hFFE7, 8'h00);
        rdchk(16'hFFE9, 8'h00);
        rdchk(16'hFFED, 8'h00);
        chk(cmd_ready, 1'b1);
        $display("test reset again done");
        end_of_test();
    end
endmodule
`default_nettype wire
